// ===== verilog/ptd_dialer.sv
// keypad, redial memory and pulse/tone sequencing of the dialer
`timescale 1ns/1ns
`default_nettype none
`include "ptd_regs.svh"
// How it works
// RQ1 - read 4x4 keypad, low level means pressed
// RQ2 - accept key after 23 ms stable closure
// RQ3 - 23 ms open guard before key released
// RQ4 - several keys ignored until one remains debounced
// RQ5 - tone mode: same row/column gives single tone
// RQ6 - fourth column blocks any single tone entry
// RQ7 - user leaves 50 ms between key entries
// RQ8 - single tone starts within 50 ms
// RQ9 - make ratio select: low gives 67% break
// RQ10 - make ratio select steady during transmission
// RQ11 - mode select: 10 pps, 20 pps or tone
// RQ12 - 26 location memory, 25 writable
// RQ13 - overflow during entry inhibits redial
// RQ14 - line dial tone key switches pulse to tone
// RQ15 - beep on every effective key entry
// RQ16 - redial replays mixed digits and stored pauses
// RQ17 - pause release skips consecutive stored pauses
// RQ18 - single tone only with its enable high
// RQ19 - flash breaks line 0.1 or 0.6 s
// RQ20 - all timing from one divided oscillator
// RQ21 - mode decode: high 20, open 10, ground tone
// RQ22 - beep is 41 ms of 1 kHz square
// RQ23 - overflowed memory refuses redial without beep
// RQ24 - intervals are tick counts of divided clock
module ptd_dialer #(
  parameter int TICK_CYC = `PTD_TICK_US * 1000 / `PTD_CLK_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // keypad lines, low while a key pulls them
  input wire logic [3:0] row_n,
  input wire logic [3:0] col_n,
  // static selects and hook state
  input wire logic make_ratio_select,
  input wire logic [1:0] dial_mode_select,
  input wire logic flash_time_select,
  input wire logic single_tone_enable,
  input wire logic hook_off,
  // line side outputs
  output logic pulse_out,
  output logic [3:0] tone_row,
  output logic [3:0] tone_col,
  output logic beep_out,
  output logic mute_on,
  output logic mode_tone
);
  import ptd_pkg::*;

  localparam int TPM = `PTD_US_PER_MS / `PTD_TICK_US; // ticks per ms
  localparam int TW = $clog2(TICK_CYC);
  localparam ptd_ticks_t DEB_T = 16'(`PTD_DEBOUNCE_MS * TPM);
  localparam ptd_ticks_t REL_T = 16'(`PTD_RELEASE_MS * TPM);
  localparam ptd_ticks_t BEEP_T = 16'(`PTD_BEEP_MS * TPM);
  localparam ptd_ticks_t HALF_T = 16'(`PTD_BEEP_HALF_US / `PTD_TICK_US);
  localparam int P10 = `PTD_PERIOD10_MS * TPM;
  localparam int P20 = `PTD_PERIOD20_MS * TPM;
  localparam ptd_ticks_t B10L = 16'(P10 * `PTD_BREAK_LONG_PCT / `PTD_PCT_FULL);
  localparam ptd_ticks_t B10S = 16'(P10 * `PTD_BREAK_SHORT_PCT / `PTD_PCT_FULL);
  localparam ptd_ticks_t B20L = 16'(P20 * `PTD_BREAK_LONG_PCT / `PTD_PCT_FULL);
  localparam ptd_ticks_t B20S = 16'(P20 * `PTD_BREAK_SHORT_PCT / `PTD_PCT_FULL);
  localparam ptd_ticks_t IDP_T = 16'(`PTD_IDP_MS * TPM);
  localparam ptd_ticks_t TONE_T = 16'(`PTD_TONE_MS * TPM);
  localparam ptd_ticks_t TGAP_T = 16'(`PTD_TONE_GAP_MS * TPM);
  localparam ptd_ticks_t PAUSE_T = 16'(`PTD_PAUSE_MS * TPM);
  localparam ptd_ticks_t FLS_T = 16'(`PTD_FLASH_SHORT_MS * TPM);
  localparam ptd_ticks_t FLL_T = 16'(`PTD_FLASH_LONG_MS * TPM);
  localparam logic [4:0] WR_MAX = 5'(`PTD_MEM_WRITABLE);

  // pin synchronisers: stage one feeds stage two only
  logic [13:0] sy1, sy2;
  logic [3:0] rows, cols;
  logic hook, ste, frs, mrs;
  logic [1:0] dms;
  // timebase
  logic [TW-1:0] pre;
  logic tick;
  // key decode and debounce
  ptd_key_t kcode, prev;
  ptd_ticks_t dcnt;
  logic held, accept;
  logic [2:0] nr, nc;
  // control state
  ptd_snd_e st;
  ptd_ticks_t t, lim, brk_t, mk_t;
  logic [3:0] pl;
  logic [4:0] scode;
  logic [1:0] mode_lat;
  logic ldt_tone, tone_mode, first, ovf, replay, skip, hook_d;
  logic [4:0] mem [`PTD_MEM_DEPTH];
  logic [4:0] wr_cnt, rd_ptr;
  logic beep_act;
  ptd_ticks_t bcnt, hcnt;

  function automatic logic [2:0] ones4(input logic [3:0] v);
    ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction : ones4

  function automatic logic [1:0] enc2(input logic [3:0] v);
    enc2 = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction : enc2

  // pulses per digit key; zero sends the longest train
  function automatic logic [3:0] pulses(input logic [3:0] k);
    if (k == `PTD_KEY_ZERO) pulses = 4'(`PTD_ZERO_PULSES);
    else pulses = 4'({2'h0, k[3:2]} * 4'h3 + {2'h0, k[1:0]} + 4'h1);
  endfunction : pulses

  // two flop sync of every pin; key lines may be driven electronically
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1 <= 14'h00FF;
      sy2 <= 14'h00FF;
    end else begin
      sy1 <= {hook_off, single_tone_enable, flash_time_select,
              make_ratio_select, dial_mode_select, col_n, row_n};
      sy2 <= sy1;
    end
  end
  assign rows = ~sy2[3:0]; // [RQ1]
  assign cols = ~sy2[7:4];
  assign dms = sy2[9:8];
  assign mrs = sy2[10];
  assign frs = sy2[11];
  assign ste = sy2[12];
  assign hook = sy2[13];

  // prescaler stands in for the resonator divider [RQ20]
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) pre <= '0;
    else if (tick) pre <= '0;
    else pre <= pre + 1'b1;
  end
  assign tick = (pre == TW'(TICK_CYC - 1)); // [RQ24]

  // matrix decode; any other combination reads as no key
  always_comb begin
    nr = ones4(rows);
    nc = ones4(cols);
    kcode = `PTD_KEY_NONE; // [RQ4]
    if (nr == 3'h1 && nc == 3'h1) kcode = {1'b0, enc2(rows), enc2(cols)};
    else if (tone_mode && !cols[3] && nr == 3'h1 && nc > 3'h1) // [RQ6]
      kcode = {3'h4, enc2(rows)}; // [RQ5]
    else if (tone_mode && !cols[3] && nc == 3'h1 && nr > 3'h1)
      kcode = {3'h5, enc2(cols)};
  end

  // debounce and release guard share one tick counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= `PTD_KEY_NONE;
      dcnt <= '0;
      held <= 1'b0;
    end else if (!hook) begin
      prev <= `PTD_KEY_NONE;
      dcnt <= '0;
      held <= 1'b0;
    end else if (kcode != prev) begin
      prev <= kcode; // any change restarts timing
      dcnt <= '0;
    end else if (tick) begin
      if (kcode == `PTD_KEY_NONE) begin
        if (dcnt == REL_T) held <= 1'b0; // [RQ3]
        else dcnt <= dcnt + 16'h1;
      end else if (!held) begin
        if (dcnt == DEB_T) held <= 1'b1;
        else dcnt <= dcnt + 16'h1;
      end
    end
  end
  // one pulse per closure, after the debounce time [RQ2]
  assign accept = hook && tick && kcode == prev && !held &&
                  kcode != `PTD_KEY_NONE && dcnt == DEB_T;

  // key classes; the sender refuses new digits while busy
  wire busy = (st != SND_IDLE) || replay;
  wire single = accept && !prev[4];
  wire [3:0] idx = prev[3:0];
  wire k_flash = single && idx == `PTD_KEY_FLASH;
  wire k_red = single && idx == `PTD_KEY_REDIAL && !busy && first &&
               !ovf && wr_cnt != 5'h0; // [RQ13] [RQ23]
  wire k_rel = single && idx == `PTD_KEY_PAUSE && replay &&
               st == SND_PAUSE;
  wire k_pst = single && idx == `PTD_KEY_PAUSE && !busy;
  wire k_ldt = single && idx == `PTD_KEY_LDT && !tone_mode && !busy;
  wire k_dig = single && idx[1:0] != 2'h3 && !busy && (tone_mode ||
               (idx != `PTD_KEY_STAR && idx != `PTD_KEY_HASH));
  wire k_st = accept && prev[4] && ste && !busy; // [RQ18]
  wire effective = k_flash | k_red | k_rel | k_pst | k_ldt | k_dig | k_st;
  wire store = k_dig | k_pst;
  wire [4:0] cur = mem[rd_ptr];
  wire rd_more = replay && st == SND_IDLE && rd_ptr < wr_cnt;
  wire rd_skip = rd_more && skip && cur[3:0] == `PTD_KEY_PAUSE;
  wire rep_go = rd_more && !rd_skip;
  wire go = rep_go | k_dig;
  wire [4:0] go_code = rep_go ? cur : {tone_mode, idx};

  // mode latched only while idle; ground means tone [RQ11] [RQ21]
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_lat <= `PTD_MODE_TONE;
      ldt_tone <= 1'b0;
      hook_d <= 1'b0;
    end else begin
      hook_d <= hook;
      if (!busy) mode_lat <= dms;
      if (!hook) ldt_tone <= 1'b0;
      else if (k_ldt) ldt_tone <= 1'b1; // [RQ14]
    end
  end
  assign tone_mode = ldt_tone || mode_lat == `PTD_MODE_TONE;

  // pulse timing from rate and make ratio select [RQ9]
  always_comb begin
    if (mode_lat == `PTD_MODE_PPS20) begin
      brk_t = mrs ? B20S : B20L;
      mk_t = 16'(P20) - brk_t;
    end else begin
      brk_t = mrs ? B10S : B10L;
      mk_t = 16'(P10) - brk_t;
    end
    unique case (st)
      SND_BREAK: lim = brk_t;
      SND_MAKE: lim = mk_t;
      SND_GAP: lim = IDP_T;
      SND_TONE: lim = TONE_T;
      SND_SILENT: lim = TGAP_T;
      SND_PAUSE: lim = PAUSE_T;
      SND_FLASH: lim = frs ? FLL_T : FLS_T; // [RQ19]
      default: lim = '0;
    endcase
  end
  wire done = tick && t == lim;

  // sender: flash overrides everything, else one entry at a time
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= SND_IDLE;
      t <= '0;
      pl <= 4'h0;
      scode <= 5'h0;
    end else if (!hook) begin
      st <= SND_IDLE;
      t <= '0;
    end else if (k_flash) begin
      st <= SND_FLASH;
      t <= '0;
    end else if (k_st) begin
      st <= SND_HOLD; // starts right after debounce [RQ8]
      scode <= prev;
    end else begin
      if (tick) t <= t + 16'h1;
      unique case (st)
        SND_IDLE: begin
          t <= '0;
          if (go) begin
            scode <= go_code;
            pl <= pulses(go_code[3:0]);
            if (go_code[3:0] == `PTD_KEY_PAUSE) st <= SND_PAUSE; // [RQ16]
            else if (go_code[4]) st <= SND_TONE;
            else st <= SND_BREAK;
          end
        end
        SND_BREAK: if (done) begin
          t <= '0;
          st <= SND_MAKE;
        end
        SND_MAKE: if (done) begin
          t <= '0;
          pl <= pl - 4'h1;
          st <= (pl == 4'h1) ? SND_GAP : SND_BREAK;
        end
        SND_TONE: if (done) begin
          t <= '0;
          st <= SND_SILENT;
        end
        SND_PAUSE: if (done || k_rel) st <= SND_IDLE; // [RQ17]
        SND_HOLD: if (kcode == `PTD_KEY_NONE) st <= SND_IDLE;
        SND_GAP, SND_SILENT, SND_FLASH: if (done) st <= SND_IDLE;
      endcase
    end
  end

  // redial memory: a storing entry that is the first effective key after off hook clears it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_cnt <= 5'h0;
      ovf <= 1'b0;
      first <= 1'b0;
    end else begin
      if (hook && !hook_d) first <= 1'b1;
      else if (effective) first <= 1'b0;
      if (store && first) begin
        wr_cnt <= 5'h1;
        ovf <= 1'b0;
      end else if (store && wr_cnt < WR_MAX) wr_cnt <= wr_cnt + 5'h1;
      else if (store) ovf <= 1'b1; // [RQ12] [RQ13]
    end
  end
  // storage array has no reset; write index follows the count
  always_ff @(posedge core_clk) begin
    if (store && first) mem[0] <= {tone_mode, idx};
    else if (store && wr_cnt < WR_MAX) mem[wr_cnt] <= {tone_mode, idx};
  end

  // replay walks the stored entries, each with its own mode
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      replay <= 1'b0;
      rd_ptr <= 5'h0;
      skip <= 1'b0;
    end else if (!hook || k_flash) begin
      replay <= 1'b0;
      skip <= 1'b0;
    end else if (k_red) begin
      replay <= 1'b1; // [RQ16]
      rd_ptr <= 5'h0;
      skip <= 1'b0;
    end else begin
      if (k_rel) skip <= 1'b1; // drop the following pauses too [RQ17]
      else if (rep_go) skip <= 1'b0;
      if (rd_skip || rep_go) rd_ptr <= rd_ptr + 5'h1;
      if (replay && st == SND_IDLE && rd_ptr == wr_cnt) replay <= 1'b0;
    end
  end

  // confirmation beep, 1 kHz square for its fixed length [RQ15] [RQ22]
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      beep_act <= 1'b0;
      bcnt <= '0;
      hcnt <= '0;
      beep_out <= 1'b0;
    end else if (effective) begin
      beep_act <= 1'b1;
      bcnt <= '0;
      hcnt <= '0;
      beep_out <= 1'b1;
    end else if (beep_act && tick) begin
      bcnt <= bcnt + 16'h1;
      hcnt <= (hcnt == HALF_T - 16'h1) ? 16'h0 : hcnt + 16'h1;
      if (hcnt == HALF_T - 16'h1) beep_out <= ~beep_out;
      if (bcnt == BEEP_T - 16'h1) begin
        beep_act <= 1'b0;
        beep_out <= 1'b0;
      end
    end
  end

  // registered line outputs; a held single tone drives one group
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_out <= 1'b0;
      tone_row <= 4'h0;
      tone_col <= 4'h0;
      mute_on <= 1'b0;
      mode_tone <= 1'b0;
    end else begin
      pulse_out <= st == SND_BREAK || st == SND_FLASH; // [RQ19]
      tone_row <= 4'h0;
      tone_col <= 4'h0;
      if (st == SND_TONE) begin
        tone_row <= 4'h1 << scode[3:2];
        tone_col <= 4'h1 << scode[1:0];
      end else if (st == SND_HOLD && ste) begin // [RQ18]
        if (!scode[2]) tone_row <= 4'h1 << scode[1:0];
        else tone_col <= 4'h1 << scode[1:0];
      end
      mute_on <= hook && (busy || beep_act);
      mode_tone <= hook && tone_mode;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  deb_accept_a: assert property (accept |-> dcnt == DEB_T && held == 1'b0 ##1 held) // [RQ2]
    else $error("key taken before debounce time");
  rel_guard_a: assert property ($fell(held) && hook |-> $past(dcnt) == REL_T) // [RQ3]
    else $error("key released before guard time");
  multi_key_a: assert property (nr > 3'h1 && nc > 3'h1 |-> kcode == `PTD_KEY_NONE) // [RQ4]
    else $error("crossed keys decoded as a key");
  keypad_column_fourth_block_a: assert property (cols[3] && (nr > 3'h1 || nc > 3'h1) |-> kcode == `PTD_KEY_NONE) // [RQ6]
    else $error("fourth column single tone decoded");
  mem_cap_a: assert property (wr_cnt <= WR_MAX) // [RQ12]
    else $error("redial count beyond writable depth");
  ovf_inhibit_a: assert property (ovf && !(store && first) |-> !k_red ##1 !$rose(replay)) // [RQ13]
    else $error("redial started after overflow");
  break_len_a: assert property (st == SND_BREAK |-> t <= brk_t && pulse_out == $past(st == SND_BREAK)) // [RQ9]
    else $error("break longer than selected ratio");
  beep_len_a: assert property (effective |=> beep_act [*8]) // [RQ15]
    else $error("beep missing after key");
  beep_end_a: assert property (beep_act |-> bcnt < BEEP_T) // [RQ22]
    else $error("beep longer than its time");
  single_en_a: assert property (st == SND_HOLD && !ste |=> tone_row == 4'h0 && tone_col == 4'h0) // [RQ18]
    else $error("single tone without enable");
  flash_line_a: assert property (st == SND_FLASH |=> pulse_out || !hook) // [RQ19]
    else $error("line not broken during flash");

  redial_c: cover property (k_red ##[1:1000] rep_go);
  flash_c: cover property (k_flash);
  single_c: cover property (k_st);
  ovf_c: cover property ($rose(ovf));
endmodule : ptd_dialer
`default_nettype wire

// ===== shared/ptd_regs.svh
// timing, key and mode constants for the pulse/tone dialer
`ifndef PTD_REGS_SVH
`define PTD_REGS_SVH
`define PTD_CLK_NS 10
`define PTD_TICK_US 100
`define PTD_US_PER_MS 1000
`define PTD_DEBOUNCE_MS 23
`define PTD_RELEASE_MS 23
`define PTD_BEEP_MS 41
`define PTD_BEEP_HALF_US 500
`define PTD_PERIOD10_MS 100
`define PTD_PERIOD20_MS 50
`define PTD_BREAK_LONG_PCT 67
`define PTD_BREAK_SHORT_PCT 61
`define PTD_PCT_FULL 100
`define PTD_IDP_MS 800
`define PTD_TONE_MS 80
`define PTD_TONE_GAP_MS 80
`define PTD_PAUSE_MS 2000
`define PTD_FLASH_SHORT_MS 100
`define PTD_FLASH_LONG_MS 600
`define PTD_MEM_DEPTH 26
`define PTD_MEM_WRITABLE 25
`define PTD_ZERO_PULSES 10
`define PTD_KEY_REDIAL 4'h3
`define PTD_KEY_PAUSE 4'h7
`define PTD_KEY_FLASH 4'hB
`define PTD_KEY_STAR 4'hC
`define PTD_KEY_ZERO 4'hD
`define PTD_KEY_HASH 4'hE
`define PTD_KEY_LDT 4'hF
`define PTD_KEY_NONE 5'h1F
`define PTD_MODE_PPS20 2'h3
`define PTD_MODE_TONE 2'h0
`endif

// ===== shared/ptd_pkg.sv
// types shared by the pulse/tone dialer
package ptd_pkg;
  // sender sequencing states
  typedef enum logic [3:0] {
    SND_IDLE, SND_BREAK, SND_MAKE, SND_GAP, SND_TONE,
    SND_SILENT, SND_PAUSE, SND_FLASH, SND_HOLD
  } ptd_snd_e;
  // debounced key code: 0rrcc single key, 100rr row, 101cc column
  typedef logic [4:0] ptd_key_t;
  typedef logic [15:0] ptd_ticks_t;
endpackage : ptd_pkg

// ===== verification/ptd_line_model.sv
// keypad matrix and line monitor that face the dialer
`timescale 1ns/1ns
`default_nettype none
module ptd_line_model (
  // clock
  input wire logic core_clk,
  // keys held by the user, one bit per key at row*4+col
  input wire logic [15:0] pressed,
  // dialer line outputs
  input wire logic pulse_out,
  input wire logic beep_out,
  // keypad lines, pulled up while no contact closes
  output logic [3:0] row_n,
  output logic [3:0] col_n,
  // what the line has seen so far
  output int n_breaks,
  output int last_break,
  output int n_beeps,
  output int beep_span
);
  int brk_len; // clocks in the current break
  int quiet; // clocks since the beep was last high
  int beep_start; // cycle of the first high of a burst
  int cyc; // free-running cycle count
  initial begin
    n_breaks = 0;
    last_break = 0;
    n_beeps = 0;
    beep_span = 0;
    brk_len = 0;
    quiet = 100;
    beep_start = 0;
    cyc = 0;
  end
  // a closed contact grounds its row and its column, common ground
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      row_n[i] = ~|pressed[i*4 +: 4];
      col_n[i] = ~|{pressed[12+i], pressed[8+i], pressed[4+i], pressed[i]};
    end
  end
  // break lengths and beep bursts; a gap of 20 clocks splits bursts
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (pulse_out === 1'b1) begin
      brk_len <= brk_len + 1;
    end else if (brk_len != 0) begin
      last_break <= brk_len;
      n_breaks <= n_breaks + 1;
      brk_len <= 0;
    end
    if (beep_out === 1'b1) begin
      quiet <= 0;
      if (quiet >= 20) begin
        n_beeps <= n_beeps + 1;
        beep_start <= cyc;
        beep_span <= 1;
      end else begin
        beep_span <= cyc - beep_start + 1;
      end
    end else begin
      quiet <= quiet + 1;
    end
  end
endmodule : ptd_line_model
`default_nettype wire

// ===== verification/ptd_dialer_tb.sv
// self-checking bench for the pulse/tone dialer
`timescale 1ns/1ns
`default_nettype none
`include "ptd_regs.svh"
module pulse_tone_dialer_keypad_control_tb_top;
  localparam int TK = 2; // clocks per tick, keeps the run short
  localparam int MS = `PTD_US_PER_MS / `PTD_TICK_US * TK; // clocks per ms
  localparam int DEB = `PTD_DEBOUNCE_MS * MS;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] pressed = 16'h0000; // keys held, bit row*4+col
  logic make_ratio_select = 1'b0;
  logic [1:0] dial_mode_select = 2'h3;
  logic flash_time_select = 1'b0;
  logic single_tone_enable = 1'b0;
  logic hook_off = 1'b0;
  logic [3:0] row_n, col_n, tone_row, tone_col;
  logic pulse_out, beep_out, mute_on, mode_tone;
  int n_breaks, last_break, n_beeps, beep_span;
  int n_fail = 0;
  int samples_checked = 0;
  ptd_dialer #(.TICK_CYC(TK)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .row_n(row_n), .col_n(col_n), .make_ratio_select(make_ratio_select),
    .dial_mode_select(dial_mode_select),
    .flash_time_select(flash_time_select),
    .single_tone_enable(single_tone_enable), .hook_off(hook_off),
    .pulse_out(pulse_out), .tone_row(tone_row), .tone_col(tone_col),
    .beep_out(beep_out), .mute_on(mute_on), .mode_tone(mode_tone));
  ptd_line_model line (.core_clk(core_clk), .pressed(pressed),
    .pulse_out(pulse_out), .beep_out(beep_out), .row_n(row_n),
    .col_n(col_n), .n_breaks(n_breaks), .last_break(last_break),
    .n_beeps(n_beeps), .beep_span(beep_span));
  always #5 core_clk = ~core_clk;
  // verdict, reached from the end of the run or from a spent wait
  task summarize;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task chk_nib(input string what, input logic [3:0] exp,
               input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_nib
  // counts and lengths from the line model, within lo..hi
  task chk_rng(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  task clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask : clk
  // hold keys, then leave more than the required gap before the next
  task press(input logic [15:0] keys, input int hold);
    pressed = keys;
    clk(hold);
    pressed = 16'h0000;
    clk(55 * MS);
  endtask : press
  // new off-hook session; selects change only while the line is idle
  task hook_new(input logic [1:0] mode, input logic mrs);
    hook_off = 1'b0;
    clk(4);
    dial_mode_select = mode;
    make_ratio_select = mrs;
    hook_off = 1'b1;
    clk(4);
  endtask : hook_new
  task wait_line(input int n, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (n_breaks >= n && pulse_out === 1'b0) break;
      clk(1);
    end
    if (i == lim) begin
      n_fail++;
      $display("unexpected breaks: expected %0d seen %0d", n, n_breaks);
      summarize();
    end
  endtask : wait_line
  // tone absence is a valid outcome, so running out is not a fault
  task wait_tone(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      clk(1);
      seen = (tone_row !== 4'h0) || (tone_col !== 4'h0);
    end
  endtask : wait_tone
  // a press shorter than the debounce, then digit 2 at 20 pps
  task t_pulse;
    int nb, b;
    hook_new(2'h3, 1'b0);
    b = n_beeps;
    press(16'h0001, DEB / 2);
    chk_rng("short press beeps", b, b, n_beeps);
    nb = n_breaks;
    press(16'h0002, DEB + 140);
    wait_line(nb + 2, 4000);
    chk_rng("beeps", b + 1, b + 1, n_beeps);
    chk_rng("beep span", 39 * MS, `PTD_BEEP_MS * MS + 2, beep_span);
    chk_rng("break", 335 * TK - 4, 335 * TK + 4, last_break);
    chk_bit("mode", 1'b0, mode_tone);
    chk_bit("mute", 1'b1, mute_on);
    clk(60 * MS);
    chk_rng("pulses", nb + 2, nb + 2, n_breaks);
    $display("test pulse finished");
  endtask : t_pulse
  // redial as first key, then redial again while it replays
  task t_redial;
    int nb, b;
    nb = n_breaks;
    b = n_beeps;
    hook_new(2'h3, 1'b0);
    press(16'h0008, DEB + 140);
    press(16'h0008, DEB + 140);
    wait_line(nb + 2, 4000);
    chk_rng("replayed pulses", nb + 2, nb + 2, n_breaks);
    chk_rng("redial beeps", b + 1, b + 1, n_beeps);
    $display("test redial finished");
  endtask : t_redial
  // 61 percent break at 10 pps and 20 pps
  task t_ratio;
    int nb, per;
    for (int k = 0; k < 2; k++) begin
      per = k ? `PTD_PERIOD20_MS : `PTD_PERIOD10_MS;
      hook_new(k ? 2'h3 : 2'h1, 1'b1);
      nb = n_breaks;
      press(16'h0001, DEB + 140);
      wait_line(nb + 1, 4000);
      chk_rng("short break", per * 61 * MS / 100 - 4,
              per * 61 * MS / 100 + 4, last_break);
    end
    $display("test ratio finished");
  endtask : t_ratio
  // dual tone, single tones by column, enable low, fourth column
  task t_tone;
    logic seen;
    int b;
    hook_new(2'h0, 1'b0);
    pressed = 16'h0020;
    wait_tone(DEB + 100, seen);
    chk_nib("dual row", 4'h2, tone_row);
    chk_nib("dual col", 4'h2, tone_col);
    chk_bit("tone mode", 1'b1, mode_tone);
    pressed = 16'h0000;
    clk(180 * MS);
    single_tone_enable = 1'b1;
    pressed = 16'h0011;
    wait_tone(DEB + 50 * MS + 10, seen);
    chk_nib("single col", 4'h1, tone_col);
    chk_nib("single row", 4'h0, tone_row);
    // dropping the enable mid-tone must silence the held group
    single_tone_enable = 1'b0;
    clk(4);
    chk_nib("single col no enable", 4'h0, tone_col);
    pressed = 16'h0000;
    clk(60 * MS);
    single_tone_enable = 1'b0;
    pressed = 16'h0011;
    wait_tone(DEB + 55 * MS, seen);
    chk_bit("tone without enable", 1'b0, seen);
    pressed = 16'h0000;
    clk(60 * MS);
    single_tone_enable = 1'b1;
    b = n_beeps;
    pressed = 16'h0088;
    wait_tone(DEB + 55 * MS, seen);
    chk_bit("fourth column tone", 1'b0, seen);
    chk_rng("fourth column beeps", b, b, n_beeps);
    pressed = 16'h0000;
    clk(60 * MS);
    single_tone_enable = 1'b0;
    $display("test tone finished");
  endtask : t_tone
  // two keys in different rows and columns, then the tone switch key
  task t_multi;
    int b;
    hook_new(2'h3, 1'b0);
    b = n_beeps;
    pressed = 16'h0021;
    clk(DEB + 200);
    chk_rng("two key beeps", b, b, n_beeps);
    pressed = 16'h0001;
    clk(DEB + 200);
    chk_rng("last key beeps", b + 1, b + 1, n_beeps);
    pressed = 16'h0000;
    hook_new(2'h3, 1'b0);
    press(16'h8000, DEB + 140);
    chk_bit("switched mode", 1'b1, mode_tone);
    $display("test multi finished");
  endtask : t_multi
  // flash for both settings of its select
  task t_flash;
    int nb, len;
    for (int f = 0; f < 2; f++) begin
      flash_time_select = f[0];
      hook_new(2'h3, 1'b0);
      nb = n_breaks;
      len = (f ? `PTD_FLASH_LONG_MS : `PTD_FLASH_SHORT_MS) * MS;
      press(16'h0800, DEB + 140);
      wait_line(nb + 1, len + 2000);
      chk_rng("flash", len - 4, len + 4, last_break);
    end
    $display("test flash finished");
  endtask : t_flash
  // overflow the redial memory with pauses, then release stored pauses
  task t_mem;
    int nb, b, n;
    n = `PTD_MEM_DEPTH;
    hook_new(2'h3, 1'b0);
    b = n_beeps;
    for (int k = 0; k < n; k++) begin
      pressed = 16'h0080;
      clk(DEB + 40);
      pressed = 16'h0000;
      clk(51 * MS);
    end
    chk_rng("pause beeps", b + n, b + n, n_beeps);
    hook_new(2'h3, 1'b0);
    nb = n_breaks;
    b = n_beeps;
    press(16'h0008, DEB + 140);
    chk_rng("overflow redial beeps", b, b, n_beeps);
    chk_rng("overflow redial pulses", nb, nb, n_breaks);
    // pause, pause, digit 1; the release must skip both pauses
    hook_new(2'h3, 1'b0);
    press(16'h0080, DEB + 140);
    press(16'h0080, DEB + 140);
    press(16'h0001, DEB + 140);
    hook_new(2'h3, 1'b0);
    nb = n_breaks;
    press(16'h0008, DEB + 140);
    press(16'h0080, DEB + 140);
    wait_line(nb + 1, 4000);
    chk_rng("released pauses", nb + 1, nb + 1, n_breaks);
    $display("test mem finished");
  endtask : t_mem
  initial begin
    clk(2);
    chk_bit("reset line", 1'b0, pulse_out);
    chk_bit("reset beep", 1'b0, beep_out);
    chk_bit("reset mode", 1'b0, mode_tone);
    chk_nib("reset tone", 4'h0, tone_row);
    arst_n = 1'b1;
    clk(4);
    t_pulse();
    t_redial();
    t_ratio();
    t_tone();
    t_multi();
    t_flash();
    t_mem();
    summarize();
  end
endmodule : pulse_tone_dialer_keypad_control_tb_top
`default_nettype wire
